// [rtl/otps_core.sv]
// Behaviour
// - otp area is four pages of 2112 bytes, addressed apart from array
// - unprogrammed lock cell reads 0, otp area still programmable
// - select bit 0 routes read, program, erase to user array
// - select bit 1 maps read/program onto otp pages 00 to 03
// - lock and select set, write enable, program execute commits lock
// - once locked, lock stays 1; otp area read only
// - status at c0h: busy, latch, efail, pfail, ecc result, reserved
// - program fail set for invalid address, locked otp, protected block
// - program fail cleared by program execute and by reset ffh
// - erase fail set for otp area select, protected block; no address check
// - erase fail cleared at block erase start and by reset ffh
// - latch follows 06h/04h; 10h and d8h ignored unless latch set
// - busy is 1 during page read, program, erase; 0 when done
// - after reset ffh busy shows init or abort progress
// - ecc result: 00 none, 01 fixed, 10 uncorrectable, 11 eight fixed
// - ecc result cleared at page read start, shows boot load result
// - power-up and every reset ffh load page 0 of block 0
// - ecc enable bit defaults to 1 after power-up and reset
`timescale 1ns/1ps
`include "otps_regs.svh"
module otps_core
  import otps_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic        si,
  output logic             so,
  output logic             soOe,
  input  wire logic        nvLock,
  output logic             nvLockProgram,
  input  wire logic        protectHit,
  output logic             arrStart,
  output otps_op_t         arrOp,
  output logic [23:0]      arrRow,
  output logic             arrOtp,
  output logic             arrEccEn,
  output logic             arrAbort,
  input  wire logic        arrDone,
  input  wire logic        arrFail,
  input  wire logic [1:0]  arrEcc,
  output logic             quadEnable
);
  logic        sclkS1, sclkS2, sclkS3, csS1, csS2, siS1, siS2;
  logic        nvS1, nvS2;
  logic [7:0]  shiftIn, opcode, featAddr, txShift;
  logic [2:0]  bitCnt, byteIdx;
  logic [23:0] rowAddr;
  otps_state_t state;
  otps_op_t    opKind;
  logic        loadPend, write_latch, pFail, eFail, otpSel, lockReq, lockDone;
  logic        eccEn;
  logic [1:0]  eccRes;

  // link pins are sampled twice before use; sclk is far slower than ref_clk
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sclkS1, sclkS2, sclkS3, siS1, siS2, nvS1, nvS2} <= 7'h00;
      {csS1, csS2} <= 2'h3;
    end else begin
      {sclkS1, sclkS2, sclkS3} <= {sclk, sclkS1, sclkS2};
      {csS1, csS2} <= {cs_b, csS1};
      {siS1, siS2} <= {si, siS1};
      {nvS1, nvS2} <= {nvLock, nvS1};
    end
  end

  wire       rise     = sclkS2 & ~sclkS3 & ~csS2;
  wire       fall     = ~sclkS2 & sclkS3 & ~csS2;
  wire [7:0] rxByte   = {shiftIn[6:0], siS2};
  wire       byteDone = rise && (bitCnt == `OTPS_BIT_LAST);
  wire       atOp     = byteDone && (byteIdx == `OTPS_IDX_OP);
  wire       isRowCmd = (opcode == `OTPS_CMD_PREAD) ||
                        (opcode == `OTPS_CMD_PEXEC) ||
                        (opcode == `OTPS_CMD_BERASE);
  wire [23:0] newRow  = {rowAddr[15:0], rxByte};
  wire       busy     = (state != OS_IDLE);
  wire       otpLock  = nvS2 | lockDone;

  // command decode
  wire cmdWren = atOp && (rxByte == `OTPS_CMD_WREN);
  wire cmdWrdi = atOp && (rxByte == `OTPS_CMD_WRDI);
  wire cmdRst  = atOp && (rxByte == `OTPS_CMD_RESET);
  wire cmdSetf = byteDone && (byteIdx == `OTPS_IDX_DATA) &&
                 (opcode == `OTPS_CMD_SETF) && (featAddr == `OTPS_FA_CONFIG);
  wire getfLoad = byteDone && (byteIdx != `OTPS_IDX_OP) &&
                  (opcode == `OTPS_CMD_GETF);
  wire cmdRow  = byteDone && (byteIdx == `OTPS_IDX_ROWEND) && isRowCmd;

  wire otpPageBad  = otpSel && (newRow >= `OTPS_OTP_PAGES);
  wire progGo      = cmdRow && (opcode == `OTPS_CMD_PEXEC) &&
                     write_latch && !busy;
  wire lockCommit  = progGo && otpSel && lockReq && !otpLock;
  wire progReject  = progGo && !lockCommit &&
                     (otpSel ? (otpLock || otpPageBad) : protectHit);
  wire progStart   = progGo && !lockCommit && !progReject;
  wire eraseGo     = cmdRow && (opcode == `OTPS_CMD_BERASE) &&
                     write_latch && !busy;
  wire eraseReject = eraseGo && (otpSel || protectHit);
  wire eraseStart  = eraseGo && !eraseReject;
  wire readStart   = cmdRow && (opcode == `OTPS_CMD_PREAD) && !busy;
  wire launch      = readStart || progStart || eraseStart || loadPend;
  wire resultIn    = arrDone && ((state == OS_BUSY) || (state == OS_INIT));

  // reserved bits are hard zero so writes to them cannot stick
  wire [7:0] cfgRead = {otpLock | lockReq, otpSel, 1'b0, eccEn,
                        3'h0, quadEnable};
  wire [7:0] stRead  = {2'h0, eccRes, pFail, eFail, write_latch, busy};
  wire [7:0] selAddr = (byteIdx == `OTPS_IDX_ADDR) ? rxByte : featAddr;
  wire [7:0] rdData  = (selAddr == `OTPS_FA_CONFIG) ? cfgRead :
                       (selAddr == `OTPS_FA_STATUS) ? stRead : 8'h00;

  // serial framing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shiftIn  <= 8'h00;
      bitCnt   <= 3'h0;
      byteIdx  <= 3'h0;
      opcode   <= 8'h00;
      featAddr <= 8'h00;
      rowAddr  <= 24'h000000;
    end else if (csS2) begin
      bitCnt  <= 3'h0;
      byteIdx <= 3'h0;
    end else if (rise) begin
      shiftIn <= rxByte;
      bitCnt  <= bitCnt + 3'h1;
      if (byteDone && byteIdx != `OTPS_IDX_MAX)
        byteIdx <= byteIdx + 3'h1;
      if (atOp)
        opcode <= rxByte;
      if (byteDone && byteIdx == `OTPS_IDX_ADDR)
        featAddr <= rxByte;
      if (byteDone && byteIdx != `OTPS_IDX_OP)
        rowAddr <= newRow;
    end
  end

  // reply reloads every byte so status can be polled without a new frame;
  // no shift on the falling edge that follows a load
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      txShift <= 8'h00;
    else if (getfLoad)
      txShift <= rdData;
    else if (fall && bitCnt != 3'h0)
      txShift <= {txShift[6:0], 1'b0};
  end
  assign so   = txShift[7];
  assign soOe = !csS2 && (opcode == `OTPS_CMD_GETF) &&
                (byteIdx >= `OTPS_IDX_DATA);

  // feature register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      otpSel     <= 1'b0;
      lockReq    <= 1'b0;
      eccEn      <= `OTPS_ECC_EN_RST;
      quadEnable <= 1'b0;
    end else if (cmdRst) begin
      otpSel  <= 1'b0;
      lockReq <= 1'b0;
      eccEn   <= `OTPS_ECC_EN_RST;
    end else if (cmdSetf) begin
      otpSel     <= rxByte[`OTPS_CFG_SEL];
      lockReq    <= rxByte[`OTPS_CFG_LOCK] && !otpLock;
      eccEn      <= rxByte[`OTPS_CFG_ECC];
      quadEnable <= rxByte[`OTPS_CFG_QUAD];
    end
  end

  // lock is one-way: nothing but reset of the flop clears it, and the
  // nonvolatile cell keeps it across power cycles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lockDone      <= 1'b0;
      nvLockProgram <= 1'b0;
    end else begin
      nvLockProgram <= lockCommit;
      if (lockCommit)
        lockDone <= 1'b1;
    end
  end

  // write latch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      write_latch <= 1'b0;
    else if (cmdWren)
      write_latch <= 1'b1;
    else if (cmdWrdi || cmdRst || progGo || eraseGo)
      write_latch <= 1'b0;
  end

  // status flags: a result arriving with a clear is kept
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pFail  <= 1'b0;
      eFail  <= 1'b0;
      eccRes <= `OTPS_ECC_NONE;
    end else begin
      if (progReject || (resultIn && opKind == OK_PROG))
        pFail <= progReject || arrFail;
      else if (progGo || cmdRst)
        pFail <= 1'b0;
      if (eraseReject || (resultIn && opKind == OK_ERASE))
        eFail <= eraseReject || arrFail;
      else if (eraseGo || cmdRst)
        eFail <= 1'b0;
      if (resultIn && opKind == OK_READ)
        eccRes <= arrEcc;
      else if (readStart || loadPend)
        eccRes <= `OTPS_ECC_NONE;
    end
  end

  // operation sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= OS_INIT;
      loadPend <= 1'b1;
      opKind   <= OK_READ;
      arrStart <= 1'b0;
      arrOp    <= OK_READ;
      arrRow   <= 24'h000000;
      arrOtp   <= 1'b0;
      arrEccEn <= `OTPS_ECC_EN_RST;
      arrAbort <= 1'b0;
    end else begin
      arrStart <= launch;
      arrAbort <= cmdRst && busy;
      if (launch) begin
        loadPend <= 1'b0;
        arrEccEn <= eccEn;
        if (loadPend) begin
          arrOp  <= OK_READ;
          opKind <= OK_READ;
          arrRow <= `OTPS_BOOT_ROW;
          arrOtp <= 1'b0;
        end else begin
          arrOp  <= readStart ? OK_READ : (progStart ? OK_PROG : OK_ERASE);
          opKind <= readStart ? OK_READ : (progStart ? OK_PROG : OK_ERASE);
          arrRow <= newRow;
          arrOtp <= otpSel;
        end
      end
      if (cmdRst && busy)
        state <= OS_ABORT;
      else if (cmdRst) begin
        state    <= OS_INIT;
        loadPend <= 1'b1;
      end else if (state == OS_ABORT && arrDone) begin
        state    <= OS_INIT;
        loadPend <= 1'b1;
      end else if (resultIn && !loadPend)
        state <= OS_IDLE;
      else if (readStart || progStart || eraseStart)
        state <= OS_BUSY;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_latch_gate: assert property (
    cmdRow && opcode == `OTPS_CMD_PEXEC && !write_latch |=> !arrStart && !$rose(busy))
    else $error("program execute ran without write latch");
  chk_pfail_clear: assert property (
    progStart |=> !pFail && arrStart && arrOp == OK_PROG)
    else $error("program fail not cleared at program start");
  chk_erase_otp: assert property (
    eraseGo && otpSel |=> eFail && !arrStart ##1 eFail)
    else $error("erase of otp area did not fail");
  chk_read_start: assert property (
    readStart |=> eccRes == `OTPS_ECC_NONE && busy && arrStart)
    else $error("page read did not clear ecc result or raise busy");
  chk_lock_sticky: assert property (
    lockDone |=> lockDone)
    else $error("otp lock dropped");
  chk_otp_route: assert property (
    progStart |=> arrOtp == $past(otpSel) && arrRow == $past(newRow))
    else $error("program not routed by otp select");
  chk_locked_prog: assert property (
    progGo && otpSel && otpLock |=> pFail && !arrStart && !busy)
    else $error("program of locked otp area not rejected");
  chk_reset_clear: assert property (
    cmdRst && !arrDone |=> !pFail && !eFail && !write_latch && busy)
    else $error("reset command did not clear flags");
  chk_boot_load: assert property (
    cmdRst && !busy |=> busy ##1 (arrStart && arrOp == OK_READ &&
                                  arrRow == `OTPS_BOOT_ROW && !arrOtp))
    else $error("reset did not load boot page");
  chk_busy_done: assert property (
    state == OS_BUSY && arrDone && !cmdRst |=> !busy ##1
      (!busy || $past(readStart || progStart || eraseStart || cmdRst)))
    else $error("busy not released after operation");
  chk_reserved_zero: assert property (
    getfLoad |=> txShift[7:6] == 2'h0 || selAddr != `OTPS_FA_STATUS)
    else $error("reserved status bits not zero");

  cov_lock: cover property (lockCommit);
  cov_prog_done: cover property (resultIn && opKind == OK_PROG);
  cov_abort: cover property (state == OS_ABORT ##[1:200] state == OS_INIT);
  cov_status_poll: cover property (getfLoad && selAddr == `OTPS_FA_STATUS);
endmodule

// [rtl/otps_regs.svh]
`ifndef OTPS_REGS_SVH
`define OTPS_REGS_SVH
`define OTPS_CMD_WREN    8'h06
`define OTPS_CMD_WRDI    8'h04
`define OTPS_CMD_SETF    8'h1f
`define OTPS_CMD_GETF    8'h0f
`define OTPS_CMD_PREAD   8'h13
`define OTPS_CMD_PEXEC   8'h10
`define OTPS_CMD_BERASE  8'hd8
`define OTPS_CMD_RESET   8'hff
`define OTPS_FA_CONFIG   8'hb0
`define OTPS_FA_STATUS   8'hc0
`define OTPS_CFG_LOCK    7
`define OTPS_CFG_SEL     6
`define OTPS_CFG_ECC     4
`define OTPS_CFG_QUAD    0
`define OTPS_ST_BUSY     0
`define OTPS_ST_WEL      1
`define OTPS_ST_EFAIL    2
`define OTPS_ST_PFAIL    3
`define OTPS_ST_ECC_LO   4
`define OTPS_ST_ECC_HI   5
`define OTPS_ECC_EN_RST  1'b1
`define OTPS_OTP_PAGES   24'h000004
`define OTPS_PAGE_BYTES  12'h840
`define OTPS_BOOT_ROW    24'h000000
`define OTPS_BIT_LAST    3'h7
`define OTPS_IDX_OP      3'h0
`define OTPS_IDX_ADDR    3'h1
`define OTPS_IDX_DATA    3'h2
`define OTPS_IDX_ROWEND  3'h3
`define OTPS_IDX_MAX     3'h7
`define OTPS_ECC_NONE    2'h0
`endif

// [rtl/otps_pkg.sv]
package otps_pkg;
  typedef enum logic [1:0] {OS_INIT, OS_IDLE, OS_BUSY, OS_ABORT} otps_state_t;
  typedef enum logic [1:0] {OK_READ, OK_PROG, OK_ERASE} otps_op_t;
endpackage

// [tb/otps_host_model.sv]
`timescale 1ns/1ps
module otps_host_model (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      cs_b,
  output logic      si,
  input  wire logic so,
  input  wire logic soOe
);
  logic oeLast;

  initial begin
    oeLast = 1'b0;
    sclk = 1'b0;
    cs_b = 1'b1;
    si   = 1'b0;
  end

  // one frame of n bytes, msb first; sclk stands low outside frames
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    repeat (2) @(posedge ref_clk);
    #1 cs_b = 1'b0;
    for (i = 0; i < n * 8; i++) begin
      si = tx[31 - i];
      repeat (4) @(posedge ref_clk);
      #1 sclk = 1'b1;
      rx = {rx[6:0], so};
      oeLast = soOe;
      repeat (4) @(posedge ref_clk);
      #1 sclk = 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    #1 cs_b = 1'b1;
    // released line must not keep its last value
    si = ~si;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// [tb/otps_core_tb.sv]
`timescale 1ns/1ps
module otps_core_tb;
  import otps_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sclk, cs_b, si, so, soOe;
  logic        nvLock = 1'b0, nvLockProgram, protectHit = 1'b0;
  logic        arrStart, arrOtp, arrEccEn, arrAbort, quadEnable;
  otps_op_t    arrOp, lastOp;
  logic [23:0] arrRow, lastRow;
  logic        arrDone = 1'b0, arrFail = 1'b0, failNext = 1'b0;
  logic [1:0]  arrEcc = 2'h0, eccNext = 2'h1;
  logic        lastOtp, lastEcc;
  logic [7:0]  v;
  int          dly = 1, nStart = 0, nAbort = 0, nLock = 0, ns, k, c;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;

  always #25 ref_clk = ~ref_clk;

  otps_host_model otps_host_model_i (.ref_clk(ref_clk), .sclk(sclk),
    .cs_b(cs_b), .si(si), .so(so), .soOe(soOe));

  otps_core otps_core_i (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .si(si), .so(so), .soOe(soOe), .nvLock(nvLock),
    .nvLockProgram(nvLockProgram), .protectHit(protectHit),
    .arrStart(arrStart), .arrOp(arrOp), .arrRow(arrRow), .arrOtp(arrOtp),
    .arrEccEn(arrEccEn), .arrAbort(arrAbort), .arrDone(arrDone),
    .arrFail(arrFail), .arrEcc(arrEcc), .quadEnable(quadEnable));

  // lock cell: once programmed it stays set
  always @(posedge ref_clk) if (nvLockProgram === 1'b1) begin
    nLock++;
    nvLock <= 1'b1;
  end

  // array responder; an abort cuts the wait short
  initial forever begin
    @(posedge ref_clk);
    if (arrStart === 1'b1 || arrAbort === 1'b1) begin
      if (arrStart === 1'b1) begin
        nStart++;
        {lastOp, lastRow, lastOtp, lastEcc} = {arrOp, arrRow, arrOtp, arrEccEn};
      end
      for (k = 0; k < dly && arrAbort !== 1'b1; k++) @(posedge ref_clk);
      if (arrAbort === 1'b1) nAbort++;
      #1 {arrDone, arrFail, arrEcc} = {1'b1, failNext, eccNext};
      @(posedge ref_clk);
      #1 arrDone = 1'b0;
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic getf(input logic [7:0] a, output logic [7:0] d);
    otps_host_model_i.xfer({8'h0f, a, 16'h0000}, 3, d);
    check("so drive", {31'h0, otps_host_model_i.oeLast}, 32'h1);
    check("so release", {31'h0, soOe}, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] row, int n);
    logic [7:0] d;
    otps_host_model_i.xfer({op, row}, n, d);
  endtask
  task automatic setf(input logic [7:0] d);
    cmd(8'h1f, {8'hb0, d, 8'h00}, 3);
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    getf(a, d);
    check(a == 8'hc0 ? "status" : "config", {24'h0, d}, {24'h0, exp});
  endtask
  task automatic wait_idle();
    logic [7:0] d;
    int i;
    d = 8'h01;
    for (i = 0; i < 20 && d[0] !== 1'b0; i++) getf(8'hc0, d);
    check("idle", {31'h0, d[0]}, 32'h0);
  endtask
  // write enable then a row command
  task automatic wrow(input logic [7:0] op, input logic [23:0] row);
    cmd(8'h06, 24'h0, 1);
    cmd(op, row, 4);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    wait_idle();
    check("boot", {nStart[3:0], lastOp, lastOtp, lastEcc, lastRow},
          {4'h1, OK_READ, 1'b0, 1'b1, 24'h0});
    reg_is(8'hc0, 8'h10);
    reg_is(8'hb0, 8'h10);
    eccNext = 2'h0;
    cmd(8'h06, 24'h0, 1);
    reg_is(8'hc0, 8'h12);
    cmd(8'h04, 24'h0, 1);
    reg_is(8'hc0, 8'h10);
    cmd(8'h10, 24'h000123, 4);
    check("no latch", nStart, 1);
    dly = 300;
    for (c = 3; c >= 0; c--) begin
      eccNext = c[1:0];
      cmd(8'h13, 24'h000123, 4);
      if (c == 3) reg_is(8'hc0, 8'h01);
      dly = 1;
      wait_idle();
      reg_is(8'hc0, {2'b00, c[1:0], 4'h0});
    end
    check("user rd", {lastOtp, lastRow}, {1'b0, 24'h000123});
    // quad set by host here; no four-line command follows
    setf(8'h7f);
    reg_is(8'hb0, 8'h51);
    check("quad", {31'h0, quadEnable}, 32'h1);
    cmd(8'h13, 24'h000002, 4);
    wait_idle();
    check("otp rd", {lastOtp, lastRow}, {1'b1, 24'h000002});
    // each otp page programmed once only
    wrow(8'h10, 24'h000003);
    wait_idle();
    check("otp pg", {lastOp, lastOtp, lastRow}, {OK_PROG, 1'b1, 24'h3});
    reg_is(8'hc0, 8'h00);
    ns = nStart;
    wrow(8'h10, 24'h000004);
    reg_is(8'hc0, 8'h08);
    wrow(8'hd8, 24'h000000);
    reg_is(8'hc0, 8'h0c);
    check("refused", nStart, ns);
    wrow(8'h10, 24'h000001);
    wait_idle();
    reg_is(8'hc0, 8'h04);
    setf(8'h01);
    wrow(8'hd8, 24'h000040);
    wait_idle();
    check("erase", {lastOp, lastOtp}, {OK_ERASE, 1'b0});
    reg_is(8'hc0, 8'h00);
    #1 protectHit = 1'b1;
    wrow(8'hd8, 24'h000080);
    reg_is(8'hc0, 8'h04);
    #1 protectHit = 1'b0;
    failNext = 1'b1;
    wrow(8'h10, 24'h000080);
    wait_idle();
    reg_is(8'hc0, 8'h0c);
    failNext = 1'b0;
    dly = 300;
    eccNext = 2'h2;
    wrow(8'h10, 24'h000081);
    cmd(8'hff, 24'h0, 1);
    getf(8'hc0, v);
    check("abort", {24'h0, v & 8'h0d}, 32'h1);
    dly = 1;
    wait_idle();
    check("aborts", nAbort, 1);
    reg_is(8'hc0, 8'h20);
    reg_is(8'hb0, 8'h11);
    setf(8'hc0);
    reg_is(8'hb0, 8'hc0);
    ns = nStart;
    wrow(8'h10, 24'h000000);
    wait_idle();
    check("lock", {nLock[3:0], nStart[3:0]}, {4'h1, ns[3:0]});
    wrow(8'h10, 24'h000000);
    reg_is(8'hc0, 8'h28);
    setf(8'h40);
    reg_is(8'hb0, 8'hc0);
    cmd(8'h13, 24'h000000, 4);
    wait_idle();
    check("locked rd", nStart, ns + 1);
    check("ecc off", {31'h0, lastEcc}, 32'h0);
    results();
  end
endmodule
